/* src/tolat_pkg.sv */
// package for the triggered output latch: constants, register map and types
package tolat_pkg;
	localparam int NUM_BYTES = 6;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] ADDR_OUT0 = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_OUT5 = 4'h5;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h8;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h9;
	localparam logic [ADDR_W-1:0] ADDR_UCNT = 4'ha;
	localparam logic [ADDR_W-1:0] ADDR_IRQS = 4'hb;
	localparam logic [ADDR_W-1:0] ADDR_IMSK = 4'hc;
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_FCLR_BIT = 1;
	localparam int STAT_SEEN_BIT = 0;
	localparam int STAT_OVF_BIT = 1;
	localparam int STAT_UND_BIT = 2;
	localparam int STAT_PEND_BIT = 3;
	localparam int IRQ_W = 3;
	localparam logic [7:0] OUT_RESET = 8'h00;
	localparam logic [7:0] UCNT_RESET = 8'h00;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	typedef enum logic [0:0] {
		TOLAT_IMMEDIATE = 1'b0,
		TOLAT_TRIGGERED = 1'b1
	} tolat_mode_e;
endpackage

/* src/tolat_edge.sv */
// trigger synchroniser and edge detector
`timescale 1ns/100ps
module tolat_edge (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic din,
	output logic rise,
	output logic fall
);
	import tolat_pkg::*;
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} tolat_edge_s;
	tolat_edge_s st, next_st;

	always_comb begin
		next_st = st;
		next_st.s1 = din;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		if (!RST_N) begin
			next_st = '0;
		end
	end

	always_ff @(posedge CLOCK) begin
		st <= next_st;
	end

	// edges only from the synchronised stages, one pulse per edge
	assign rise = st.s2 & ~st.s3;
	assign fall = ~st.s2 & st.s3;
endmodule

/* src/tolat_irq.sv */
// sticky event status with write-one-to-clear and mask
`timescale 1ns/100ps
module tolat_irq (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic [tolat_pkg::IRQ_W-1:0] events,
	input wire logic clr_we,
	input wire logic mask_we,
	input wire logic [tolat_pkg::IRQ_W-1:0] wdata,
	output logic [tolat_pkg::IRQ_W-1:0] status,
	output logic [tolat_pkg::IRQ_W-1:0] mask,
	output logic irq
);
	import tolat_pkg::*;
	typedef struct packed {
		logic [IRQ_W-1:0] status;
		logic [IRQ_W-1:0] mask;
	} tolat_irq_s;
	tolat_irq_s st, next_st;

	always_comb begin
		next_st = st;
		// a set in the clearing cycle wins
		if (clr_we) begin
			next_st.status = st.status & ~wdata;
		end
		next_st.status = next_st.status | events;
		if (mask_we) begin
			next_st.mask = wdata;
		end
		if (!RST_N) begin
			next_st = '0;
		end
	end

	always_ff @(posedge CLOCK) begin
		st <= next_st;
	end

	assign status = st.status;
	assign mask = st.mask;
	assign irq = |(st.status & st.mask);
endmodule

/* src/tolat_top.sv */
// triggered output latch: six byte groups, immediate or trigger-updated
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module tolat_top (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic [tolat_pkg::ADDR_W-1:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic EXT_TRIG,
	output logic [15:0] PORT0,
	output logic [15:0] PORT1,
	output logic [15:0] PORT2,
	output logic IRQ
);
	import tolat_pkg::*;

	typedef struct packed {
		logic [NUM_BYTES-1:0][7:0] outq;
		logic [NUM_BYTES-1:0][7:0] hold;
		logic [NUM_BYTES-1:0] written;
		logic [1:0] ctrl;
		logic seen;
		logic ovf;
		logic pend;
		logic [7:0] ucnt;
		logic [7:0] rdata;
	} tolat_top_s;

	tolat_top_s st, next_st;
	logic rise, fall;
	logic [IRQ_W-1:0] irq_status, irq_mask, events;
	logic out_we, triggered, fclr, underrun, overflow;

	function automatic logic is_out_addr(input logic [ADDR_W-1:0] a);
		return (a >= ADDR_OUT0) && (a <= ADDR_OUT5);
	endfunction

	////////////////////////////////////////////////////////////////////////////

	tolat_edge u_edge (
		.CLOCK(CLOCK),
		.RST_N(RST_N),
		.din(EXT_TRIG),
		.rise(rise),
		.fall(fall)
	);

	tolat_irq u_irq (
		.CLOCK(CLOCK),
		.RST_N(RST_N),
		.events(events),
		.clr_we(WR && ADDR == ADDR_IRQS),
		.mask_we(WR && ADDR == ADDR_IMSK),
		.wdata(WDATA[IRQ_W-1:0]),
		.status(irq_status),
		.mask(irq_mask),
		.irq(IRQ)
	);

	////////////////////////////////////////////////////////////////////////////

	assign out_we = WR && is_out_addr(ADDR);
	assign triggered = (st.ctrl[CTRL_MODE_BIT] == TOLAT_TRIGGERED);
	assign fclr = st.ctrl[CTRL_FCLR_BIT];
	// underrun: edge arrives with nothing written since the last transfer
	assign underrun = triggered && rise && !st.pend && !out_we;
	assign overflow = triggered && out_we && st.written[ADDR[2:0]] && !rise;
	assign events = {underrun, overflow, triggered && rise};

	always_comb begin
		next_st = st;
		next_st.rdata = 8'h00;
		if (triggered && rise) begin
			next_st.outq = st.hold;
			next_st.written = '0;
			next_st.pend = 1'b0;
			next_st.seen = 1'b1;
			if (underrun) begin
				next_st.ucnt = st.ucnt + 8'h01;
			end
		end
		if (triggered && fall && fclr) begin
			next_st.outq = '0;
			next_st.hold = '0;
		end
		if (out_we) begin
			if (triggered) begin
				// only the buffer moves; latest write wins at the next edge
				next_st.hold[ADDR[2:0]] = WDATA;
				next_st.pend = 1'b1;
				if (!rise) begin
					next_st.written[ADDR[2:0]] = 1'b1;
				end
				next_st.seen = 1'b0;
			end else begin
				next_st.outq[ADDR[2:0]] = WDATA;
				next_st.hold[ADDR[2:0]] = WDATA;
			end
		end
		if (overflow) begin
			next_st.ovf = 1'b1;
		end
		if (WR && ADDR == ADDR_CTRL) begin
			next_st.ctrl = WDATA[1:0];
		end
		if (WR && ADDR == ADDR_STAT && WDATA[STAT_OVF_BIT]) begin
			next_st.ovf = overflow;
		end
		if (WR && ADDR == ADDR_UCNT) begin
			next_st.ucnt = UCNT_RESET;
		end
		if (RD) begin
			case (ADDR)
				ADDR_CTRL: next_st.rdata = {6'h00, st.ctrl};
				ADDR_STAT: next_st.rdata = {4'h0, st.pend, 1'b0, st.ovf, st.seen};
				ADDR_UCNT: next_st.rdata = st.ucnt;
				ADDR_IRQS: next_st.rdata = {5'h00, irq_status};
				ADDR_IMSK: next_st.rdata = {5'h00, irq_mask};
				default: begin
					if (is_out_addr(ADDR)) begin
						next_st.rdata = st.outq[ADDR[2:0]];
					end else begin
						next_st.rdata = 8'h00;
					end
				end
			endcase
		end
		if (!RST_N) begin
			next_st = '0;
			next_st.ctrl = CTRL_RESET;
			next_st.ucnt = UCNT_RESET;
		end
	end

	always_ff @(posedge CLOCK) begin
		st <= next_st;
	end

	// three connectors of sixteen lines each, two byte groups per port
	assign PORT0 = {st.outq[1], st.outq[0]};
	assign PORT1 = {st.outq[3], st.outq[2]};
	assign PORT2 = {st.outq[5], st.outq[4]};
	assign RDATA = st.rdata;
endmodule

/* bench/tolat_trig_src.sv */
// stand-in for the external trigger source
`timescale 1ns/100ps
module tolat_trig_src (
	input wire logic level,
	output logic EXT_TRIG
);
	// follows our clock-driven level 3 ns late, so edges land off the sampling edge
	assign #3 EXT_TRIG = level;
endmodule

/* bench/tolat_chk.sv */
// port checker for the triggered output latch
`timescale 1ns/100ps
module tolat_chk
	import tolat_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic [tolat_pkg::ADDR_W-1:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire logic EXT_TRIG,
	input wire logic [15:0] PORT0,
	input wire logic [15:0] PORT1,
	input wire logic [15:0] PORT2,
	input wire logic IRQ
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	////////////////////////////////
	property p_rst_out; disable iff (1'b0) !RST_N |=> {PORT0, PORT1, PORT2} == 48'h0; endproperty
	a_rst_out: assert property (p_rst_out) else $error("ports on in reset");
	property p_rst_irq; disable iff (1'b0) !RST_N |=> !IRQ; endproperty
	a_rst_irq: assert property (p_rst_irq) else $error("irq in reset");
	property p_rd_idle; !RD |=> RDATA == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata without read");
	property p_rd_out; RD && ADDR == ADDR_OUT0 |=> RDATA == $past(PORT0[7:0]); endproperty
	a_rd_out: assert property (p_rd_out) else $error("byte read differs");
	property p_rd_unmap; RD && (ADDR > ADDR_IMSK || ADDR inside {4'h6, 4'h7}) |=> RDATA == 8'h00; endproperty
	a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read");
	// a transfer lands 2 to 4 clocks after the trigger level is first sampled
	property p_port_cause; $changed({PORT0, PORT1, PORT2}) |->
		$past(WR) || $past(EXT_TRIG, 2) != $past(EXT_TRIG, 5); endproperty
	a_port_cause: assert property (p_port_cause) else $error("port moved alone");
	property p_irq_rise; $rose(IRQ) |-> $past(WR) || $past(WR, 2) ||
		$past(EXT_TRIG, 2) != $past(EXT_TRIG, 6); endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq without event");
	property p_irq_fall; $fell(IRQ) |-> $past(WR) || $past(WR, 2); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
	////////////////////////////////
	c_ctrl: cover property (WR && ADDR == ADDR_CTRL);
	c_xfer: cover property ($changed(PORT0) && !$past(WR));
	c_irq: cover property ($rose(IRQ));
endmodule
bind tolat_top tolat_chk u_chk (.CLOCK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .EXT_TRIG,
	.PORT0, .PORT1, .PORT2, .IRQ);

/* bench/testbench.sv */
// self-checking bench for the triggered output latch
`timescale 1ns/100ps
module testbench;
	import tolat_pkg::*;
	logic CLOCK = 0, RST_N = 0, WR = 0, RD = 0, trig = 0, EXT_TRIG, IRQ;
	logic [ADDR_W-1:0] ADDR = 0;
	logic [7:0] WDATA = 0, RDATA;
	logic [15:0] PORT0, PORT1, PORT2;
	int n_mismatch = 0, check_count = 0, cyc = 0;
	tolat_top u_dut (.CLOCK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .EXT_TRIG,
		.PORT0, .PORT1, .PORT2, .IRQ);
	tolat_trig_src u_src (.level(trig), .EXT_TRIG);
	initial begin
		forever #12.5 CLOCK = ~CLOCK;
	end
	// whole run is well under 600 clocks
	always @(posedge CLOCK) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			complete_run();
		end
	end
	////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic tk(int n);
		repeat (n) @(posedge CLOCK);
		#1;
	endtask
	task automatic wr(logic [ADDR_W-1:0] a, logic [7:0] d);
		@(posedge CLOCK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLOCK);
		WR <= 1'b0;
	endtask
	task automatic rd(logic [ADDR_W-1:0] a, logic [7:0] m, logic [7:0] exp);
		@(posedge CLOCK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLOCK);
		RD <= 1'b0;
		#1;
		chk("rdata", {8'h0, exp}, {8'h0, RDATA & m});
	endtask
	task automatic pulse(logic v);
		@(posedge CLOCK);
		trig <= v;
		tk(6);
	endtask
	////////////////////////////////
	task automatic t_reset();
		tk(1);
		chk("ports", 16'h0, PORT0 | PORT1 | PORT2);
		chk("irq", 16'h0, {15'h0, IRQ});
		rd(ADDR_CTRL, 8'hff, 8'h00);
	endtask
	task automatic t_imm();
		for (int i = 0; i < NUM_BYTES; i++) begin
			wr(4'(i), 8'(8'h11 * (i + 1)));
		end
		tk(1);
		chk("port0", 16'h2211, PORT0);
		chk("port1", 16'h4433, PORT1);
		chk("port2", 16'h6655, PORT2);
		rd(ADDR_OUT5, 8'hff, 8'h66);
		rd(ADDR_OUT0, 8'hff, 8'h11);
		rd(4'hf, 8'hff, 8'h00);
	endtask
	task automatic t_trig();
		wr(ADDR_IMSK, 8'h07);
		wr(ADDR_CTRL, 8'h01);
		wr(ADDR_OUT0, 8'ha5);
		wr(ADDR_OUT0, 8'h3c);
		tk(1);
		chk("hold", 16'h2211, PORT0);
		pulse(1'b1);
		chk("xfer", 16'h223c, PORT0);
		rd(ADDR_STAT, 8'h03, 8'h03);
		rd(ADDR_IRQS, 8'h07, 8'h03);
		chk("irq", 16'h1, {15'h0, IRQ});
		pulse(1'b0);
		pulse(1'b1);
		rd(ADDR_UCNT, 8'hff, 8'h01);
		wr(4'h2, 8'h5a);
		rd(ADDR_STAT, 8'h01, 8'h00);
		chk("hold1", 16'h4433, PORT1);
		wr(ADDR_IRQS, 8'h07);
		wr(ADDR_IMSK, 8'h00);
		tk(1);
		chk("irq clr", 16'h0, {15'h0, IRQ});
		pulse(1'b0);
		pulse(1'b1);
		chk("xfer1", 16'h445a, PORT1);
		chk("masked", 16'h0, {15'h0, IRQ});
		rd(ADDR_UCNT, 8'hff, 8'h01);
	endtask
	task automatic t_fclr();
		wr(ADDR_CTRL, 8'h03);
		pulse(1'b0);
		chk("fclr", 16'h0000, PORT0);
		wr(4'h1, 8'hff);
		pulse(1'b1);
		chk("xfer2", 16'hff00, PORT0);
		pulse(1'b0);
		chk("fclr2", 16'h0000, PORT0);
	endtask
	initial begin
		repeat (8) @(posedge CLOCK);
		RST_N <= 1'b1;
		t_reset();
		t_imm();
		t_trig();
		t_fclr();
		complete_run();
	end
endmodule
